// *** verilog/isas_sequencer.sv ***
// Sequencer, calibration loops and output stage of a 16-way
// interleaved SAR converter, with an Avalon-MM register slave.
// Assumes latched comparators clocked by core_clk; only the output
// enable pin comes from outside the clock domain.
`timescale 1ns/1ns
module isas_sequencer
    import isas_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_MIN_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // Analog array control
    input wire logic [NUM_SECT-1:0] cmp_in,
    output logic [NUM_SECT-1:0] zero_sample_en,
    output logic [NUM_SECT-1:0] autozero_en,
    output logic [NUM_SECT-1:0] autocal_en,
    output logic [NUM_SECT-1:0] input_sample_en,
    output logic [NUM_SECT*SAR_BITS-1:0] dac_code,
    output logic [NUM_SECT*TRIM_W-1:0] offset_trim,
    output logic [NUM_SECT*TRIM_W-1:0] gain_msb_trim,
    output logic [NUM_SECT*TRIM_W-1:0] gain_lsb_trim,
    // Output pins
    input wire logic out_en_n,
    output logic [CODE_BITS-1:0] sample_code,
    output logic sample_code_oe,
    output logic overrange_flag,
    output logic overrange_oe,
    output logic word_valid_strobe
);

    // Refuse a calibration count the counter cannot hold
    if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << CAL_CNT_W)) begin : g_cal_chk
        $error("CAL_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Phase generator
    logic [STEP_W-1:0] phase_r;
    logic [STEP_W-1:0] phase_nxt;
    logic [STEP_W-1:0] xfer_sel;
    assign phase_nxt = phase_r + 4'h1;
    // Section in its transfer step this cycle
    assign xfer_sel = phase_r + 4'h1;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion sections
    logic [SAR_BITS-1:0] sar_r [NUM_SECT];
    logic [NUM_SECT-1:0] zero_r;
    logic [NUM_SECT-1:0] az_r;
    logic [NUM_SECT-1:0] ac_r;
    logic [NUM_SECT-1:0] samp_r;
    for (genvar s = 0; s < NUM_SECT; s++) begin : g_sect
        logic [STEP_W-1:0] step;
        logic [STEP_W-1:0] step_nxt;
        logic [STEP_W-1:0] bpos;
        logic [TRIM_W-1:0] off_r;
        logic [TRIM_W-1:0] gmsb_r;
        logic [TRIM_W-1:0] glsb_r;
        logic [INTEG_W-1:0] integ_r;
        logic gsel_r;
        assign step = phase_r - STEP_W'(s);
        assign step_nxt = phase_nxt - STEP_W'(s);
        assign bpos = STEP_SAR_LAST - step;
        // step strobes aligned to the step
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                zero_r[s] <= 1'b0;
                az_r[s] <= 1'b0;
                ac_r[s] <= 1'b0;
                samp_r[s] <= 1'b0;
            end else begin
                zero_r[s] <= (step_nxt == STEP_ZERO);
                az_r[s] <= (step_nxt == STEP_AZ);
                ac_r[s] <= (step_nxt == STEP_AC);
                samp_r[s] <= (step_nxt == STEP_SAMP);
            end
        end
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                sar_r[s] <= '0;
            end else if (step == STEP_SAMP) begin
                sar_r[s] <= OVR_THRESH;
            end else if (step >= STEP_SAR0 && step <= STEP_SAR_LAST) begin
                // keep or drop the trial bit
                sar_r[s][bpos] <= cmp_in[s];
                if (bpos != 4'h0) begin
                    sar_r[s][bpos-4'h1] <= 1'b1;
                end
            end
        end
        // auto-zero loop, one trim step per pass
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                off_r <= TRIM_MID;
            end else if (step == STEP_AZ) begin
                if (cmp_in[s] && off_r != TRIM_MIN) begin
                    off_r <= off_r - 6'h01;
                end else if (!cmp_in[s] && off_r != TRIM_MAX) begin
                    off_r <= off_r + 6'h01;
                end
            end
        end
        // gain error integrated before a trim step
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                integ_r <= INTEG_MID;
                gsel_r <= 1'b0;
                gmsb_r <= TRIM_MID;
                glsb_r <= TRIM_MID;
            end else if (step == STEP_AC) begin
                if (cmp_in[s] && integ_r == INTEG_MAX) begin
                    integ_r <= INTEG_MID;
                    gsel_r <= ~gsel_r;
                    if (!gsel_r && gmsb_r != TRIM_MIN) begin
                        gmsb_r <= gmsb_r - 6'h01;
                    end
                    if (gsel_r && glsb_r != TRIM_MIN) begin
                        glsb_r <= glsb_r - 6'h01;
                    end
                end else if (!cmp_in[s] && integ_r == INTEG_MIN) begin
                    integ_r <= INTEG_MID;
                    gsel_r <= ~gsel_r;
                    if (!gsel_r && gmsb_r != TRIM_MAX) begin
                        gmsb_r <= gmsb_r + 6'h01;
                    end
                    if (gsel_r && glsb_r != TRIM_MAX) begin
                        glsb_r <= glsb_r + 6'h01;
                    end
                end else if (cmp_in[s]) begin
                    integ_r <= integ_r + 4'h1;
                end else begin
                    integ_r <= integ_r - 4'h1;
                end
            end
        end
        // Flattened views of section flops
        assign dac_code[s*SAR_BITS +: SAR_BITS] = sar_r[s];
        assign offset_trim[s*TRIM_W +: TRIM_W] = off_r;
        assign gain_msb_trim[s*TRIM_W +: TRIM_W] = gmsb_r;
        assign gain_lsb_trim[s*TRIM_W +: TRIM_W] = glsb_r;
    end
    assign zero_sample_en = zero_r;
    assign autozero_en = az_r;
    assign autocal_en = ac_r;
    assign input_sample_en = samp_r;

    ////////////////////////////////////////////////////////////////////
    // Calibration timer
    isas_cal_e cal_st_r;
    logic [CAL_CNT_W-1:0] cal_cnt_r;
    logic cal_done_evt;
    assign cal_done_evt = (cal_st_r == CAL_WARMUP) &&
        (cal_cnt_r == CAL_CNT_W'(CAL_CYCLES - 1));
    // starts at reset release, counts the least time
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cal_st_r <= CAL_WARMUP;
            cal_cnt_r <= '0;
        end else begin
            case (cal_st_r)
                CAL_WARMUP: begin
                    cal_cnt_r <= cal_cnt_r + 1'b1;
                    if (cal_done_evt) begin
                        cal_st_r <= CAL_TRACK;
                    end
                end
                CAL_TRACK: begin
                    cal_st_r <= CAL_TRACK;
                end
                default: begin
                    cal_st_r <= CAL_WARMUP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output multiplexer and pins
    logic en_n_meta_r;
    logic en_n_sync_r;
    logic primed_r;
    logic word_new;
    logic [SAR_BITS-1:0] xfer_word;
    logic xfer_ovr;
    logic [CODE_BITS-1:0] code_r;
    logic ovr_r;
    logic oe_r;
    logic dav_r;
    assign xfer_word = sar_r[xfer_sel];
    assign xfer_ovr = (xfer_word >= OVR_THRESH);
    assign word_new = primed_r || (phase_r == PHASE_PRIMED);
    // Enable pin synchroniser
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_n_meta_r <= 1'b1;
            en_n_sync_r <= 1'b1;
        end else begin
            en_n_meta_r <= out_en_n;
            en_n_sync_r <= en_n_meta_r;
        end
    end
    // First real sample reaches the mux
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            primed_r <= 1'b0;
        end else if (phase_r == PHASE_PRIMED) begin
            primed_r <= 1'b1;
        end
    end
    // transfer step lands twelve clocks after sampling
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            code_r <= '0;
            ovr_r <= 1'b0;
            dav_r <= 1'b0;
        end else begin
            dav_r <= word_new;
            if (word_new) begin
                code_r <= xfer_ovr ? '1 : xfer_word[CODE_BITS-1:0];
                ovr_r <= xfer_ovr;
            end
        end
    end
    // drive only while enable is low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= ~en_n_sync_r;
        end
    end
    assign sample_code = code_r;
    assign overrange_flag = ovr_r;
    assign sample_code_oe = oe_r;
    assign overrange_oe = oe_r;
    assign word_valid_strobe = dav_r;

    ////////////////////////////////////////////////////////////////////
    // Register slave and interrupt
    logic wait_r;
    logic [31:0] rdata_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [OVR_CNT_W-1:0] ovr_cnt_r;
    logic irq_r;
    logic wr_go;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    assign wr_go = avs_write && !wait_r;
    assign irq_set = {word_new && xfer_ovr, cal_done_evt};
    assign irq_clr = (wr_go && avs_address == REG_IRQ_STAT) ?
        avs_writedata[IRQ_W-1:0] : '0;
    // One wait cycle, then a one-cycle answer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
        end
    end
    // Read data captured with the request
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (avs_read && wait_r) begin
            case (avs_address)
                REG_STATUS: begin
                    rdata_r <= 32'((cal_st_r == CAL_TRACK) << STAT_CAL_DONE) |
                        32'(phase_r) << STAT_PHASE_LSB;
                end
                REG_IRQ_STAT: rdata_r <= 32'(irq_stat_r);
                REG_IRQ_MASK: rdata_r <= 32'(irq_mask_r);
                REG_OVR_CNT: rdata_r <= 32'(ovr_cnt_r);
                default: rdata_r <= '0;
            endcase
        end
    end
    // Sticky status, set wins over clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end
    // Interrupt mask
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_mask_r <= '0;
        end else if (wr_go && avs_address == REG_IRQ_MASK) begin
            irq_mask_r <= avs_writedata[IRQ_W-1:0];
        end
    end
    // Overrange word count, wraps
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovr_cnt_r <= '0;
        end else if (irq_set[IRQ_OVR]) begin
            ovr_cnt_r <= ovr_cnt_r + 1'b1;
        end
    end
    // Level interrupt
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign irq = irq_r;

endmodule

// *** verilog/isas_pkg.sv ***
// Shared constants of the interleaved converter sequencer.
// Assumes one core clock; the analog array sits on the same clock.
package isas_pkg;
    // Array shape
    localparam int NUM_SECT = 16;
    localparam int SAR_BITS = 11;
    localparam int CODE_BITS = 10;
    localparam int STEP_W = 4;
    // Steps of a section sequence, counted from zero
    localparam logic [3:0] STEP_ZERO = 4'h0;
    localparam logic [3:0] STEP_AZ = 4'h1;
    localparam logic [3:0] STEP_AC = 4'h2;
    localparam logic [3:0] STEP_SAMP = 4'h3;
    localparam logic [3:0] STEP_SAR0 = 4'h4;
    localparam logic [3:0] STEP_SAR_LAST = 4'he;
    localparam logic [3:0] STEP_XFER = 4'hf;
    // First phase at which a transferred word holds a real sample
    localparam logic [3:0] PHASE_PRIMED = 4'hd;
    // Trim and integrator ranges
    localparam int TRIM_W = 6;
    localparam logic [5:0] TRIM_MID = 6'h20;
    localparam logic [5:0] TRIM_MAX = 6'h3f;
    localparam logic [5:0] TRIM_MIN = 6'h00;
    localparam int INTEG_W = 4;
    localparam logic [3:0] INTEG_MID = 4'h8;
    localparam logic [3:0] INTEG_MAX = 4'hf;
    localparam logic [3:0] INTEG_MIN = 4'h0;
    // Overrange: full scale plus one LSB
    localparam logic [10:0] OVR_THRESH = 11'h400;
    // Least calibration time after power-up, in clock cycles
    localparam int CAL_MIN_CYCLES = 10000;
    localparam int CAL_CNT_W = 14;
    // Register byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;
    localparam logic [3:0] REG_OVR_CNT = 4'hc;
    // Field positions
    localparam int STAT_CAL_DONE = 0;
    localparam int STAT_PHASE_LSB = 4;
    localparam int IRQ_CAL_DONE = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_W = 2;
    localparam int OVR_CNT_W = 16;
    // Calibration phase
    typedef enum logic [1:0] {
        CAL_WARMUP = 2'b01,
        CAL_TRACK = 2'b10
    } isas_cal_e;
endpackage

// *** dv/isas_sequencer_properties.sv ***
// Checker for the converter sequencer, seeing only its top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module isas_props
    import isas_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_MIN_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Section steps
    input wire logic [NUM_SECT-1:0] zero_sample_en,
    input wire logic [NUM_SECT-1:0] autozero_en,
    input wire logic [NUM_SECT-1:0] autocal_en,
    input wire logic [NUM_SECT-1:0] input_sample_en,
    // Output pins
    input wire logic out_en_n,
    input wire logic [CODE_BITS-1:0] sample_code,
    input wire logic sample_code_oe,
    input wire logic overrange_flag,
    input wire logic overrange_oe,
    input wire logic word_valid_strobe
);
    logic [4:0] up_cnt_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////
    // Cycles since reset release, saturating
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            up_cnt_r <= 5'h00;
        end else if (up_cnt_r != 5'h1f) begin
            up_cnt_r <= up_cnt_r + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    one_sampler_a: assert property (up_cnt_r > 5'h04 |-> $onehot(input_sample_en))
        else $error("not exactly one section sampling");
    step_chain_a: assert property (up_cnt_r > 5'h04 |-> autozero_en == $past(zero_sample_en)
        && autocal_en == $past(autozero_en) && input_sample_en == $past(autocal_en))
        else $error("section steps out of order");
    sample_rotate_a: assert property (up_cnt_r > 5'h04 |->
        input_sample_en == {$past(input_sample_en[14:0]), $past(input_sample_en[15])})
        else $error("sampling section did not advance by one");
    period_16_a: assert property (up_cnt_r == 5'h1f |->
        zero_sample_en == $past(zero_sample_en, 16))
        else $error("sequence does not repeat every 16 cycles");
    strobe_quiet_a: assert property (up_cnt_r < 5'h09 |-> !word_valid_strobe)
        else $error("strobe before first word");
    strobe_steady_a: assert property (up_cnt_r > 5'h10 |-> word_valid_strobe)
        else $error("strobe missing in steady run");
    ovr_code_a: assert property (overrange_flag |-> sample_code == 10'h3ff)
        else $error("code not all ones during overrange");
    drive_on_a: assert property (!out_en_n [*3] ##1 (!out_en_n && up_cnt_r > 5'h02)
        |-> sample_code_oe && overrange_oe)
        else $error("outputs not driven while enabled");
    drive_off_a: assert property (out_en_n [*4] |-> !sample_code_oe && !overrange_oe)
        else $error("outputs driven while disabled");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait state");
    unmapped_zero_a: assert property (avs_read && avs_waitrequest
        && avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind isas_sequencer isas_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .zero_sample_en(zero_sample_en),
    .autozero_en(autozero_en), .autocal_en(autocal_en), .input_sample_en(input_sample_en),
    .out_en_n(out_en_n), .sample_code(sample_code), .sample_code_oe(sample_code_oe),
    .overrange_flag(overrange_flag), .overrange_oe(overrange_oe),
    .word_valid_strobe(word_valid_strobe));

// *** dv/isas_capture.sv ***
// Capture logic model on the far side of the converter output pins.
// Assumes the pins and the converter share one clock.
`timescale 1ns/1ns
module isas_capture
    import isas_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_MIN_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Converter pins
    input wire logic [CODE_BITS-1:0] sample_code,
    input wire logic sample_code_oe,
    input wire logic overrange_flag,
    input wire logic overrange_oe,
    input wire logic word_valid_strobe,
    // Wire levels and captured word
    output logic [CODE_BITS-1:0] bus_code,
    output logic bus_ovr,
    output logic [CODE_BITS:0] word_r,
    output logic word_early
);
    logic [CODE_BITS:0] last_r = '0;
    int age_r = 0;

    ////////////////////////////////////////////////////////////////
    // Floating pins show the inverse of their level one cycle earlier
    always_comb begin
        bus_code = sample_code_oe ? sample_code : ~last_r[CODE_BITS-1:0];
        bus_ovr = overrange_oe ? overrange_flag : ~last_r[CODE_BITS];
    end
    // Pin level of the last cycle, driven or floating
    always_ff @(posedge core_clk) begin
        last_r <= {bus_ovr, bus_code};
    end
    // words before calibration time marked inaccurate
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            age_r <= 0;
        end else if (age_r < CAL_CYCLES) begin
            age_r <= age_r + 1;
        end
        if (word_valid_strobe) begin
            word_r <= {bus_ovr, bus_code};
            word_early <= age_r < CAL_CYCLES;
        end
    end
endmodule

// *** dv/isas_sequencer_tb.sv ***
// Testbench for the converter sequencer: registers, calibration,
// output stream and tri-state control. Assumes a model of the analog array.
`timescale 1ns/1ns
module isas_sequencer_tb
    import isas_pkg::*;
;
    localparam int CAL_N = 20;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, irq, sample_code_oe, overrange_flag, overrange_oe;
    logic word_valid_strobe, bus_ovr;
    logic [NUM_SECT-1:0] cmp_in, zero_sample_en, autozero_en, autocal_en, input_sample_en;
    logic [NUM_SECT*SAR_BITS-1:0] dac_code;
    logic [NUM_SECT*TRIM_W-1:0] offset_trim, gain_msb_trim;
    logic [CODE_BITS:0] cap_word;
    logic cap_early;
    logic out_en_n = 1'b0;
    logic [CODE_BITS-1:0] sample_code, bus_code;
    logic [10:0] analog_in = 11'h000;
    logic [10:0] held [NUM_SECT] = '{default: 11'h000};
    int num_errors = 0;
    int checked = 0;

    ////////////////////////////////////////////////////////////////
    // Clock, free running with even duty
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    isas_sequencer #(.CAL_CYCLES(CAL_N)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .cmp_in(cmp_in), .zero_sample_en(zero_sample_en), .autozero_en(autozero_en),
        .autocal_en(autocal_en), .input_sample_en(input_sample_en), .dac_code(dac_code),
        .offset_trim(offset_trim), .gain_msb_trim(gain_msb_trim), .gain_lsb_trim(),
        .out_en_n(out_en_n),
        .sample_code(sample_code), .sample_code_oe(sample_code_oe),
        .overrange_flag(overrange_flag), .overrange_oe(overrange_oe),
        .word_valid_strobe(word_valid_strobe));

    isas_capture #(.CAL_CYCLES(CAL_N)) u_cap (
        .core_clk(core_clk), .sys_rst(sys_rst), .sample_code(sample_code),
        .sample_code_oe(sample_code_oe), .overrange_flag(overrange_flag),
        .overrange_oe(overrange_oe), .word_valid_strobe(word_valid_strobe),
        .bus_code(bus_code), .bus_ovr(bus_ovr), .word_r(cap_word), .word_early(cap_early));

    ////////////////////////////////////////////////////////////////
    // Per-section track-and-hold on the shared input
    always_ff @(posedge core_clk) begin
        for (int s = 0; s < NUM_SECT; s++) begin
            if (input_sample_en[s]) begin
                held[s] <= analog_in;
            end
        end
    end
    // Comparators: held sample against the trial word
    always_comb begin
        for (int s = 0; s < NUM_SECT; s++) begin
            cmp_in[s] = held[s] >= dac_code[s*SAR_BITS +: SAR_BITS];
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        chk("bus answer", n < 20, 1'b1);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Calibration status, interrupt raise, mask, clear, unmapped place
    task automatic t_cal;
        av_xfer(1'b0, REG_STATUS, 32'h0);
        chk("cal done early", rd[STAT_CAL_DONE], 1'b0);
        av_xfer(1'b0, REG_IRQ_MASK, 32'h0);
        chk("mask reset", rd, 32'h0);
        repeat (CAL_N) @(posedge core_clk);
        av_xfer(1'b1, REG_STATUS, 32'h0);
        av_xfer(1'b0, REG_STATUS, 32'h0);
        chk("cal done", rd[STAT_CAL_DONE], 1'b1);
        chk("irq masked", irq, 1'b0);
        av_xfer(1'b0, REG_IRQ_STAT, 32'h0);
        chk("cal event", rd[IRQ_CAL_DONE], 1'b1);
        av_xfer(1'b1, REG_IRQ_MASK, 32'h1);
        @(posedge core_clk);
        chk("irq raised", irq, 1'b1);
        av_xfer(1'b1, REG_IRQ_STAT, 32'h1);
        @(posedge core_clk);
        chk("irq cleared", irq, 1'b0);
        av_xfer(1'b1, 4'h6, 32'hffffffff);
        av_xfer(1'b0, 4'h6, 32'h0);
        chk("unmapped read", rd, 32'h0);
        av_xfer(1'b0, REG_IRQ_MASK, 32'h0);
        chk("mask kept", rd, 32'h1);
    endtask

    // Tri-state control from the enable pin
    task automatic t_oe;
        out_en_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("code drive off", sample_code_oe, 1'b0);
        chk("flag drive off", overrange_oe, 1'b0);
        out_en_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk("code drive on", sample_code_oe, 1'b1);
        chk("flag drive on", overrange_oe, 1'b1);
    endtask

    // Input changing every cycle; each word checked 13 cycles after its sample
    task automatic t_stream;
        logic [10:0] vals [7] = '{11'h000, 11'h3ff, 11'h400, 11'h7ff, 11'h155, 11'h2aa, 11'h001};
        logic [10:0] pv [13];
        logic pok [13] = '{default: 1'b0};
        int i, k, ovr_n;
        ovr_n = 0;
        av_xfer(1'b1, REG_IRQ_MASK, 32'h3);
        for (i = 0; i < 160; i++) begin
            @(posedge core_clk);
            if (pok[12]) begin
                chk("strobe", word_valid_strobe, 1'b1);
                chk("code", bus_code, pv[12] >= 11'h400 ? 10'h3ff : pv[12][9:0]);
                chk("overrange", bus_ovr, pv[12] >= 11'h400);
            end
            for (k = 12; k > 0; k--) begin
                pv[k] = pv[k-1];
                pok[k] = pok[k-1];
            end
            pv[0] = analog_in;
            pok[0] = |input_sample_en;
            ovr_n += int'(pok[0] && pv[0] >= 11'h400);
            analog_in <= vals[i % 7];
        end
        @(posedge core_clk);
        analog_in <= 11'h000;
        repeat (20) @(posedge core_clk);
        chk("irq overrange", irq, 1'b1);
        chk("captured word", cap_word, 11'h000);
        chk("late word flag", cap_early, 1'b0);
        chk("offset trim", offset_trim[TRIM_W-1:0] < TRIM_MID, 1'b1);
        chk("msb gain trim", gain_msb_trim[TRIM_W-1:0] < TRIM_MID, 1'b1);
        av_xfer(1'b0, REG_OVR_CNT, 32'h0);
        chk("overrange count", rd, ovr_n);
        av_xfer(1'b1, REG_IRQ_STAT, 32'h2);
        av_xfer(1'b0, REG_IRQ_STAT, 32'h0);
        chk("overrange cleared", rd[IRQ_OVR], 1'b0);
        chk("irq dropped", irq, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_cal;
        t_oe;
        t_stream;
        end_sim;
    end

    // Watchdog
    initial begin
        #20000;
        num_errors++;
        end_sim;
    end
endmodule
